// file: design/clk_io_port.v
// clock block with reference divider and edge delays, driving one buffered
// 1-bit port with an 8-bit transfer register; registers reached over apb
// assumes ref_clk is a level made by logic on pclk, and pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "clk_io_port_regs.vh"

module clk_io_port (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // reference clock level
   input wire ref_clk,
   // pins
   input wire ext_clk_pin,
   input wire ready_pin,
   input wire data_pin_i,
   output reg data_pin_o,
   output reg data_pin_oe,
   // error indication
   output reg err_pulse,
   output reg err_is_port
);

   // ********************************
   // pin synchronisers
   // ********************************
   wire [2:0] pin_raw;
   wire [2:0] pin_f;
   assign pin_raw = {data_pin_i, ready_pin, ext_clk_pin};
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : sync
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg f_q;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               f_q <= 1'b0;
            end else begin
               s1_q <= pin_raw[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // change counts only once two stages agree
               if (s2_q == s3_q)
                  f_q <= s3_q;
            end
         end
         assign pin_f[g] = f_q;
      end
   endgenerate

   // ********************************
   // bus decode
   // ********************************
   wire [7:0] a = paddr;
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire [3:0] op = pwdata[`CMD_OP];
   wire [9:0] arg = pwdata[`CMD_ARG];
   wire hit = (a == `RG_CMD) | (a == `RG_STATUS) | (a == `RG_TXDATA) | (a == `RG_PSC) |
      (a == `RG_TIME) | (a == `RG_RXDATA) | (a == `RG_PEEK) | (a == `RG_ENDIN) |
      (a == `RG_TSTAMP);
   reg on_q, run_q, stop_q, srcp_q;
   reg [7:0] div_q;
   reg [9:0] rise_q, fall_q;
   reg tx_v_q;
   wire tx_wr = wr & (a == `RG_TXDATA);
   // a full transmit word stalls the master rather than losing data
   wire tx_hold = tx_wr & tx_v_q & on_q;
   assign pready = ~tx_hold;
   assign pslverr = acc & ~hit;
   wire wdone = wr & ~tx_hold & hit;
   wire rdone = acc & ~pwrite & hit;
   wire cmd_wr = wdone & (a == `RG_CMD);

   // ********************************
   // command checks
   // ********************************
   reg cerr;
   always @* begin
      cerr = 1'b0;
      if (op >= `OP_CLK_START && op <= `OP_READY && !on_q)
         cerr = 1'b1;
      else begin
         case (op)
            `OP_EDGE_SRC: cerr = (arg != `PW_ARG) | (div_q != 8'h00);
            `OP_DIV: cerr = srcp_q | (arg > `DIV_MAX);
            `OP_RISE: cerr = arg > `DLY_MAX;
            `OP_FALL: cerr = arg > `DLY_MAX;
            `OP_READY: cerr = arg != `PW_ARG;
            default: cerr = 1'b0;
         endcase
      end
   end
   wire cok = cmd_wr & ~cerr;
   wire clk_init = cok & (op == `OP_CLK_ON);
   wire clk_start = cok & (op == `OP_CLK_START);
   wire [1:0] dly_wr = {cok & (op == `OP_FALL), cok & (op == `OP_RISE)};
   wire psc_wr = wdone & (a == `RG_PSC);
   wire psc_bad = (pwdata == 32'h0000_0000) | (pwdata >= {28'h000_0000, `TW_BITS}) |
      ((pwdata[3:0] % `PW_BITS) != `CNT_ZERO);
   wire perr = (psc_wr & psc_bad) | (tx_wr & ~on_q);

   // ********************************
   // clock source and divider
   // ********************************
   reg ref_d_q, dck_q, src_d_q;
   reg [7:0] dcnt_q;
   // reference level arrives at its reset rate
   wire ref_rise = ref_clk & ~ref_d_q;
   wire src_lvl = srcp_q ? pin_f[0] : ((div_q == 8'h00) ? ref_clk : dck_q);
   wire src_rise = run_q & src_lvl & ~src_d_q;
   wire src_fall = run_q & ~src_lvl & src_d_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q <= 1'b0;
         run_q <= 1'b0;
         stop_q <= 1'b0;
         srcp_q <= 1'b0;
         div_q <= 8'h00;
         rise_q <= `DLY_ZERO;
         fall_q <= `DLY_ZERO;
         ref_d_q <= 1'b0;
         dck_q <= 1'b0;
         dcnt_q <= 8'h00;
         src_d_q <= 1'b0;
      end else begin
         ref_d_q <= ref_clk;
         src_d_q <= src_lvl;
         if (div_q == 8'h00) begin
            dcnt_q <= 8'h00;
            dck_q <= 1'b0;
         end else if (ref_rise) begin
            if (dcnt_q == div_q - 8'h01) begin
               dcnt_q <= 8'h00;
               dck_q <= ~dck_q;
            end else
               dcnt_q <= dcnt_q + 8'h01;
         end
         // stop waits for a low clock so no runt pulse reaches the port
         if (stop_q & ~src_lvl) begin
            run_q <= 1'b0;
            stop_q <= 1'b0;
         end
         if (cok) begin
            case (op)
               // on loads defaults, also when already on
               `OP_CLK_ON: begin
                  on_q <= 1'b1;
                  run_q <= 1'b0;
                  stop_q <= 1'b0;
                  srcp_q <= 1'b0;
                  div_q <= 8'h00;
                  rise_q <= `DLY_ZERO;
                  fall_q <= `DLY_ZERO;
               end
               `OP_CLK_OFF: begin
                  on_q <= 1'b0;
                  run_q <= 1'b0;
                  stop_q <= 1'b0;
               end
               `OP_CLK_START: begin
                  run_q <= 1'b1;
                  stop_q <= 1'b0;
               end
               `OP_CLK_STOP: stop_q <= run_q;
               `OP_EDGE_SRC: srcp_q <= 1'b1;
               `OP_REF_SRC: srcp_q <= 1'b0;
               `OP_DIV: begin
                  div_q <= arg[7:0];
                  dcnt_q <= 8'h00;
               end
               `OP_RISE: rise_q <= arg;
               `OP_FALL: fall_q <= arg;
               default: ;
            endcase
         end
      end
   end

   // ********************************
   // edge delays, rise then fall
   // ********************************
   generate
      for (g = 0; g < 2; g = g + 1) begin : edg
         wire ev = (g == 0) ? src_rise : src_fall;
         wire [9:0] dly = (g == 0) ? rise_q : fall_q;
         reg pend_q, sup_q;
         reg [9:0] cnt_q;
         wire fire = ~sup_q & ((ev & (dly == `DLY_ZERO)) | (pend_q & (cnt_q == `DLY_LAST)));
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_q <= 1'b0;
               sup_q <= 1'b0;
               cnt_q <= `DLY_ZERO;
            end else if (clk_init | dly_wr[g]) begin
               pend_q <= 1'b0;
               sup_q <= 1'b0;
               cnt_q <= `DLY_ZERO;
            end else if (ev & (dly != `DLY_ZERO)) begin
               // next edge before delivery means delay beyond period
               if (pend_q & (cnt_q != `DLY_LAST))
                  sup_q <= 1'b1;
               pend_q <= 1'b1;
               cnt_q <= dly;
            end else if (pend_q) begin
               cnt_q <= cnt_q - `DLY_LAST;
               pend_q <= (cnt_q != `DLY_LAST);
            end
         end
      end
   endgenerate
   wire ck_rise = edg[0].fire;
   wire ck_fall = edg[1].fire;

   // ********************************
   // buffered port
   // ********************************
   reg port_on_q, rdy_q, psc_v_q, tm_v_q, rx_v_q, end_q, sync_q;
   reg [7:0] tx_q, osr_q, isr_q, rx_q;
   reg [3:0] tx_n_q, psc_q, ocnt_q, icnt_q;
   reg [15:0] tm_q, pc_q, ts_q;
   wire pop = rdone & (a == `RG_RXDATA);
   wire endin = rdone & (a == `RG_ENDIN);
   wire pop_ok = cmd_wr & ((op == `OP_PORT_START) | (op == `OP_CLEARBUF));
   wire [3:0] itgt = psc_v_q ? psc_q : `TW_BITS;
   // timed output waits for matching counter
   wire load = ck_fall & port_on_q & (ocnt_q == `CNT_ZERO) & tx_v_q & (~tm_v_q | (pc_q == tm_q));
   wire [3:0] icnt_n = icnt_q + `PW_BITS;
   // ready-in gates sampling
   // a held word pauses sampling one bit short, so no completed word is lost
   wire samp = ck_rise & port_on_q & ~data_pin_oe & ~end_q & ~tx_v_q &
      (~rdy_q | pin_f[1]) & ~(rx_v_q & (icnt_n == itgt));
   wire [7:0] isr_n = {pin_f[2], isr_q[7:1]};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_on_q <= 1'b0;
         rdy_q <= 1'b0;
         psc_v_q <= 1'b0;
         tm_v_q <= 1'b0;
         tx_v_q <= 1'b0;
         rx_v_q <= 1'b0;
         end_q <= 1'b0;
         sync_q <= 1'b0;
         tx_q <= 8'h00;
         osr_q <= 8'h00;
         isr_q <= 8'h00;
         rx_q <= 8'h00;
         tx_n_q <= `CNT_ZERO;
         psc_q <= `CNT_ZERO;
         ocnt_q <= `CNT_ZERO;
         icnt_q <= `CNT_ZERO;
         tm_q <= 16'h0000;
         pc_q <= 16'h0000;
         ts_q <= 16'h0000;
         data_pin_o <= 1'b0;
         data_pin_oe <= 1'b0;
      end else begin
         if (clk_start)
            pc_q <= 16'h0000;
         else if (ck_rise)
            pc_q <= pc_q + 16'h0001;
         if (load) begin
            // only the requested low bits leave
            data_pin_o <= tx_q[0];
            data_pin_oe <= 1'b1;
            osr_q <= {1'b0, tx_q[7:1]};
            ocnt_q <= tx_n_q - `PW_BITS;
            tx_v_q <= 1'b0;
            tm_v_q <= 1'b0;
            ts_q <= pc_q;
         end else if (ck_fall & (ocnt_q != `CNT_ZERO)) begin
            data_pin_o <= osr_q[0];
            osr_q <= {1'b0, osr_q[7:1]};
            ocnt_q <= ocnt_q - `PW_BITS;
         end
         // done one fall after the last bit left
         if (sync_q & ck_fall & ~load & ~tx_v_q & (ocnt_q == `CNT_ZERO))
            sync_q <= 1'b0;
         if (pop)
            rx_v_q <= 1'b0;
         if (samp) begin
            // at the target the word is captured and the count restarts from zero
            isr_q <= isr_n;
            if ((icnt_n == itgt) & ~rx_v_q) begin
               rx_q <= isr_n;
               rx_v_q <= 1'b1;
               icnt_q <= `CNT_ZERO;
               psc_v_q <= 1'b0;
               ts_q <= pc_q;
            end else
               icnt_q <= icnt_n;
         end
         // remainder lands in the top bits
         if (end_q & ~rx_v_q & ~pop) begin
            if (icnt_q != `CNT_ZERO) begin
               rx_q <= isr_q;
               rx_v_q <= 1'b1;
               icnt_q <= `CNT_ZERO;
            end else
               end_q <= 1'b0;
         end
         if (endin)
            end_q <= 1'b1;
         if (wdone & (a == `RG_TXDATA) & on_q) begin
            tx_q <= pwdata[7:0];
            tx_v_q <= 1'b1;
            tx_n_q <= psc_v_q ? psc_q : `TW_BITS;
            psc_v_q <= 1'b0;
         end
         if (psc_wr & ~psc_bad) begin
            psc_q <= pwdata[3:0];
            psc_v_q <= 1'b1;
         end
         if (wdone & (a == `RG_TIME)) begin
            tm_q <= pwdata[`TIME_VAL];
            tm_v_q <= pwdata[`TIME_ARM];
         end
         if (cok & (op == `OP_READY))
            rdy_q <= 1'b1;
         if (cmd_wr & (op == `OP_PORT_STOP)) begin
            port_on_q <= 1'b0;
            rdy_q <= 1'b0;
         end
         if (cmd_wr & (op == `OP_SYNC))
            sync_q <= 1'b1;
         // buffers emptied; pin level and enable left as driven
         if (pop_ok) begin
            tx_v_q <= 1'b0;
            tm_v_q <= 1'b0;
            ocnt_q <= `CNT_ZERO;
            rx_v_q <= 1'b0;
            icnt_q <= `CNT_ZERO;
            end_q <= 1'b0;
            sync_q <= 1'b0;
         end
         if (cmd_wr & (op == `OP_PORT_START))
            port_on_q <= 1'b1;
      end
   end

   // ********************************
   // read data and error pulse
   // ********************************
   reg [31:0] rd_mux;
   always @* begin
      case (a)
         `RG_STATUS: rd_mux = {8'h00, div_q, 6'h00, sync_q, end_q, rx_v_q, tx_v_q,
            data_pin_oe, rdy_q, port_on_q, srcp_q, run_q, on_q};
         `RG_RXDATA: rd_mux = {24'h00_0000, rx_q};
         // peek sees the filtered pin alone
         `RG_PEEK: rd_mux = {31'h0000_0000, pin_f[2]};
         `RG_ENDIN: rd_mux = {27'h000_0000, {1'b0, icnt_q} + (rx_v_q ? 5'h08 : 5'h00)};
         `RG_TSTAMP: rd_mux = {16'h0000, ts_q};
         `RG_TIME: rd_mux = {15'h0000, tm_v_q, tm_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         err_pulse <= 1'b0;
         err_is_port <= 1'b0;
      end else begin
         // captured in the setup phase so the access edge sees a stable word
         if (psel & ~penable)
            prdata <= rd_mux;
         err_pulse <= (cmd_wr & cerr) | perr;
         err_is_port <= perr;
      end
   end

endmodule // clk_io_port

`default_nettype wire

// file: inc/clk_io_port_regs.vh
// register map, command codes and limits of the clock block and buffered port
// assumes it is included by bare name from the design file, the checker and the bench
`ifndef CLK_IO_PORT_REGS_VH
`define CLK_IO_PORT_REGS_VH

// register byte offsets
`define RG_CMD 8'h00
`define RG_STATUS 8'h04
`define RG_TXDATA 8'h08
`define RG_PSC 8'h0C
`define RG_TIME 8'h10
`define RG_RXDATA 8'h14
`define RG_PEEK 8'h18
`define RG_ENDIN 8'h1C
`define RG_TSTAMP 8'h20

// command and time register fields
`define CMD_OP 3:0
`define CMD_ARG 25:16
`define TIME_VAL 15:0
`define TIME_ARM 16

// command opcodes
`define OP_NONE 4'h0
`define OP_CLK_ON 4'h1
`define OP_CLK_OFF 4'h2
`define OP_CLK_START 4'h3
`define OP_CLK_STOP 4'h4
`define OP_EDGE_SRC 4'h5
`define OP_REF_SRC 4'h6
`define OP_DIV 4'h7
`define OP_RISE 4'h8
`define OP_FALL 4'h9
`define OP_READY 4'hA
`define OP_PORT_START 4'hB
`define OP_PORT_STOP 4'hC
`define OP_CLEARBUF 4'hD
`define OP_SYNC 4'hE

// limits and widths
`define DIV_MAX 10'h0FF
`define DLY_MAX 10'h200
`define DLY_ZERO 10'h000
`define DLY_LAST 10'h001
`define PW_ARG 10'h001
`define TW_BITS 4'h8
`define PW_BITS 4'h1
`define CNT_ZERO 4'h0
`define REF_RESET_MHZ 100

`endif

// file: verification/clk_io_port_assertions.sv
// concurrent checks on the apb side and pins of clk_io_port
// assumes it is bound to clk_io_port and that the register header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "clk_io_port_regs.vh"
// ****
// checker
// ****
module clk_io_port_assertions (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   // pins and errors
   input wire data_pin_o,
   input wire data_pin_oe,
   input wire err_pulse,
   input wire err_is_port
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire take = psel && penable && pready && pwrite;
   wire [9:0] arg = pwdata[`CMD_ARG];
   sequence s_cmd(logic [3:0] op);
      take && paddr == `RG_CMD && pwdata[`CMD_OP] == op;
   endsequence
   a_err_single: assert property (err_pulse |=> !err_pulse)
      else $error("error pulse longer than one cycle");
   a_err_cause: assert property (err_pulse |-> $past(take))
      else $error("error pulse without a write");
   a_div_range: assert property (s_cmd(`OP_DIV) ##0 arg > `DIV_MAX |=> err_pulse && !err_is_port)
      else $error("divide above limit accepted");
   a_edge_width: assert property (s_cmd(`OP_EDGE_SRC) ##0 arg != `PW_ARG |=> err_pulse)
      else $error("wide edge source accepted");
   a_ready_width: assert property (s_cmd(`OP_READY) ##0 arg != `PW_ARG |=> err_pulse)
      else $error("wide ready source accepted");
   a_rise_range: assert property (s_cmd(`OP_RISE) ##0 arg > `DLY_MAX |=> err_pulse)
      else $error("rise delay above limit accepted");
   a_fall_range: assert property (s_cmd(`OP_FALL) ##0 arg > `DLY_MAX |=> err_pulse)
      else $error("fall delay above limit accepted");
   a_psc_range: assert property (take && paddr == `RG_PSC && (pwdata == 32'h0 || pwdata > 32'h7)
      |=> err_pulse && err_is_port)
      else $error("bad partial count accepted");
   a_clear_hold: assert property (s_cmd(`OP_CLEARBUF) |=> ##1
      ($stable(data_pin_o) && $stable(data_pin_oe)) [*4])
      else $error("pins moved after clear");
endmodule // clk_io_port_assertions
`default_nettype wire

// file: verification/pin_model.sv
// far side of the port: reference level, external clock, ready and data pins
// assumes the bench steers it from pclk and that pins are sampled asynchronously
`timescale 1ns/1ps
`default_nettype none
// ****
// pin model
// ****
module pin_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench controls
   input wire logic en,
   input wire logic lvl,
   input wire logic rdy,
   input wire logic [7:0] pat,
   // pins
   input wire logic data_pin_o,
   input wire logic data_pin_oe,
   output logic ref_clk,
   output logic ext_clk_pin,
   output wire logic ready_pin,
   output wire logic data_pin_i
);
   logic [2:0] ph_q;
   logic [2:0] idx_q;
   logic bit_q;
   assign ready_pin = rdy;
   // single wire clock, low between frames, data moves on falls
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_clk <= 1'h0;
         ext_clk_pin <= 1'h0;
         ph_q <= 3'h0;
         idx_q <= 3'h0;
         bit_q <= 1'h0;
      end else begin
         ref_clk <= ~ref_clk;
         ph_q <= en ? ph_q + 3'h1 : 3'h0;
         if (!en) begin
            ext_clk_pin <= 1'h0;
            idx_q <= 3'h0;
            bit_q <= pat[0];
         end else if (ph_q == 3'h7) begin
            ext_clk_pin <= ~ext_clk_pin;
            if (ext_clk_pin) begin
               idx_q <= idx_q + 3'h1;
               bit_q <= pat[idx_q + 3'h1];
            end
         end
      end
   end
   // the device wins the wire while it drives
   assign data_pin_i = data_pin_oe ? data_pin_o : (en ? bit_q : lvl);
endmodule // pin_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for clk_io_port over apb with a pin model
// assumes the design, the pin model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "clk_io_port_regs.vh"
// ****
// bench
// ****
module tb_top;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, obits = 32'h0;
   logic en = 1'h0, lvl = 1'h0, rdy = 1'h0;
   logic [7:0] pat = 8'h3C;
   wire [31:0] prdata;
   wire pready, pslverr, ref_clk, ext_clk_pin, ready_pin, data_pin_i;
   wire data_pin_o, data_pin_oe, err_pulse, err_is_port;
   int bad_count = 0, total_checks = 0, errs = 0, perrs = 0, cyc = 0, ocnt = 0;
   logic rerr = 1'h0;
   longint t0 = 0;
   always #20 pclk = ~pclk;
   clk_io_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ref_clk(ref_clk), .ext_clk_pin(ext_clk_pin), .ready_pin(ready_pin),
      .data_pin_i(data_pin_i), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe),
      .err_pulse(err_pulse), .err_is_port(err_is_port));
   pin_model i_pins (.pclk(pclk), .presetn(presetn), .en(en), .lvl(lvl), .rdy(rdy), .pat(pat),
      .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .ref_clk(ref_clk),
      .ext_clk_pin(ext_clk_pin), .ready_pin(ready_pin), .data_pin_i(data_pin_i));
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // error pulses seen before this edge's updates land
   always @(posedge pclk) begin
      cyc++;
      if (err_pulse === 1'h1) begin
         errs++;
         perrs += (err_is_port === 1'h1);
      end
      if (cyc == 40000) begin
         bad_count++;
         $display("[ERR] %0t run too long", $time);
         finish_test;
      end
   end
   // mid-bit sampling of driven output
   always @(posedge ext_clk_pin) begin
      if (data_pin_oe === 1'h1 && ocnt < 32) begin
         obits[ocnt] = data_pin_o;
         ocnt++;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // write, then count error pulses and port errors it caused
   task wr_e(input logic [7:0] a, input logic [31:0] d, input int e, input int p);
      int e0;
      int p0;
      e0 = errs;
      p0 = perrs;
      apb(1'h1, a, d);
      repeat (2) @(posedge pclk);
      chk(errs - e0, e);
      chk(perrs - p0, p);
   endtask
   function logic [31:0] cw(input logic [3:0] op, input logic [9:0] arg);
      return {6'h00, arg, 12'h000, op};
   endfunction
   task st(input int b, input logic v);
      apb(1'h0, `RG_STATUS, 32'h0);
      while (rd[b] !== v) begin
         apb(1'h0, `RG_STATUS, 32'h0);
      end
   endtask
   task ext_wait(input int n);
      repeat (n) @(posedge ext_clk_pin);
      @(posedge pclk);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `RG_STATUS, 32'h0);
      chk(rd, 32'h0);
      wr_e(`RG_CMD, cw(`OP_CLK_START, 10'h0), 1, 0);
      wr_e(`RG_CMD, cw(`OP_CLK_OFF, 10'h0), 0, 0);
      wr_e(`RG_TXDATA, 32'h5A, 1, 1);
      wr_e(`RG_CMD, cw(`OP_CLK_ON, 10'h0), 0, 0);
      wr_e(`RG_CMD, cw(`OP_DIV, 10'h100), 1, 0);
      wr_e(`RG_CMD, cw(`OP_DIV, `DIV_MAX), 0, 0);
      wr_e(`RG_CMD, cw(`OP_EDGE_SRC, `PW_ARG), 1, 0);
      wr_e(`RG_CMD, cw(`OP_REF_SRC, 10'h0), 0, 0);
      apb(1'h0, `RG_STATUS, 32'h0);
      chk({24'h0, rd[23:16]}, 32'hFF);
      wr_e(`RG_CMD, cw(`OP_CLK_ON, 10'h0), 0, 0);
      apb(1'h0, `RG_STATUS, 32'h0);
      chk(rd, 32'h1);
      wr_e(`RG_CMD, cw(`OP_EDGE_SRC, 10'h2), 1, 0);
      wr_e(`RG_CMD, cw(`OP_EDGE_SRC, `PW_ARG), 0, 0);
      wr_e(`RG_CMD, cw(`OP_DIV, 10'h3), 1, 0);
      wr_e(`RG_CMD, cw(`OP_READY, 10'h2), 1, 0);
      wr_e(`RG_CMD, cw(`OP_READY, `PW_ARG), 0, 0);
      wr_e(`RG_CMD, cw(`OP_RISE, 10'h201), 1, 0);
      wr_e(`RG_CMD, cw(`OP_FALL, 10'h201), 1, 0);
      wr_e(`RG_CMD, cw(`OP_FALL, `DLY_MAX), 0, 0);
      wr_e(`RG_CMD, cw(`OP_FALL, `DLY_ZERO), 0, 0);
      wr_e(`RG_PSC, 32'h0, 1, 1);
      wr_e(`RG_PSC, 32'h8, 1, 1);
      apb(1'h0, 8'h24, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      wr_e(`RG_CMD, cw(`OP_CLK_START, 10'h0), 0, 0);
      wr_e(`RG_CMD, cw(`OP_PORT_START, 10'h0), 0, 0);
      // ready low, then overlong rise delay: nothing may be sampled
      en <= 1'h1;
      ext_wait(10);
      apb(1'h0, `RG_STATUS, 32'h0);
      chk({31'h0, rd[7]}, 32'h0);
      wr_e(`RG_CMD, cw(`OP_RISE, `DLY_MAX), 0, 0);
      rdy <= 1'h1;
      ext_wait(10);
      apb(1'h0, `RG_STATUS, 32'h0);
      chk({31'h0, rd[7]}, 32'h0);
      en <= 1'h0;
      wr_e(`RG_CMD, cw(`OP_RISE, `DLY_ZERO), 0, 0);
      en <= 1'h1;
      st(7, 1'h1);
      en <= 1'h0;
      apb(1'h0, `RG_ENDIN, 32'h0);
      chk(rd, 32'h8);
      apb(1'h0, `RG_RXDATA, 32'h0);
      chk(rd, {24'h0, pat});
      for (int v = 0; v < 2; v++) begin
         lvl <= v[0];
         repeat (8) @(posedge pclk);
         apb(1'h0, `RG_PEEK, 32'h0);
         chk({31'h0, rd[0]}, {31'h0, v[0]});
      end
      en <= 1'h1;
      st(7, 1'h1);
      en <= 1'h0;
      wr_e(`RG_CMD, cw(`OP_PORT_START, 10'h0), 0, 0);
      apb(1'h0, `RG_STATUS, 32'h0);
      chk({31'h0, rd[7]}, 32'h0);
      // full word then a three bit partial word, then sync
      en <= 1'h1;
      wr_e(`RG_TXDATA, 32'hA5, 0, 0);
      st(6, 1'h0);
      wr_e(`RG_PSC, 32'h3, 0, 0);
      wr_e(`RG_TXDATA, 32'hFE, 0, 0);
      wr_e(`RG_CMD, cw(`OP_SYNC, 10'h0), 0, 0);
      st(9, 1'h0);
      chk({31'h0, ocnt >= 11}, 32'h1);
      chk({21'h0, obits[10:0]}, 32'h6A5);
      wr_e(`RG_CMD, cw(`OP_CLK_START, 10'h0), 0, 0);
      wr_e(`RG_TIME, 32'h0001_0028, 0, 0);
      wr_e(`RG_TXDATA, 32'h0F, 0, 0);
      st(6, 1'h0);
      apb(1'h0, `RG_TSTAMP, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h28);
      wr_e(`RG_TXDATA, 32'h55, 0, 0);
      wr_e(`RG_CMD, cw(`OP_CLEARBUF, 10'h0), 0, 0);
      apb(1'h0, `RG_STATUS, 32'h0);
      chk({31'h0, rd[6]}, 32'h0);
      chk({31'h0, data_pin_oe}, 32'h1);
      // aborted word had high low bits; its zero top bits must never appear
      ext_wait(5);
      chk({31'h0, data_pin_o}, 32'h1);
      // reference source, divide two: one source period is eight pclk cycles
      wr_e(`RG_CMD, cw(`OP_CLK_ON, 10'h0), 0, 0);
      wr_e(`RG_CMD, cw(`OP_DIV, 10'h2), 0, 0);
      wr_e(`RG_CMD, cw(`OP_CLK_START, 10'h0), 0, 0);
      wr_e(`RG_TXDATA, 32'h55, 0, 0);
      @(negedge data_pin_o);
      t0 = $time;
      @(posedge data_pin_o);
      chk(32'($time - t0), 32'h140);
      finish_test;
   end
endmodule // tb_top
bind clk_io_port clk_io_port_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe), .err_pulse(err_pulse),
   .err_is_port(err_is_port));
`default_nettype wire
